// ---- hw/cdv_pkg.sv ----
// Constants, types and helpers shared by the cable diagnostic block
package cdv_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_WIN_BOUNDS = 6'h17;
  localparam logic [5:0] IDX_PEAK_RES   = 6'h18;
  localparam logic [5:0] IDX_THR_RES    = 6'h19;
  localparam logic [5:0] IDX_VAR_CTRL   = 6'h1A;
  localparam logic [5:0] IDX_VAR_DATA   = 6'h1B;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         WIN_START_LSB  = 8;
  localparam int         PEAK_VAL_LSB   = 8;
  localparam int         THR_MET_BIT    = 8;
  localparam int         VAR_RDY_BIT    = 15;
  localparam int         VAR_FRZ_BIT    = 3;
  localparam int         VAR_SEL_LSB    = 1;
  localparam int         VAR_EN_BIT     = 0;
  localparam logic [7:0] WIN_START_RST  = 8'h00;
  localparam logic [7:0] WIN_STOP_RST   = 8'hFF;
  localparam logic [1:0] VAR_SEL_RST    = 2'h0;
  localparam logic [5:0] SAMPLE_MIN     = 6'h00;
  localparam logic [5:0] SAMPLE_MAX     = 6'h3F;
  localparam logic [7:0] TIME_LAST      = 8'hFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned VAR_UNIT_NS     = 1048576;
  localparam int unsigned VAR_UNIT_CYCLES = VAR_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned VAR_UNITS_STEP  = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CDV_CAP_IDLE = 2'b00,
    CDV_CAP_RUN  = 2'b01,
    CDV_CAP_DONE = 2'b10
  } cdv_cap_e;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic cdv_hit(input logic [7:0] addr,
                                   input logic [5:0] idx);
    cdv_hit = (addr == {idx, 2'b00});
  endfunction : cdv_hit

  function automatic logic [31:0] cdv_period_len(input logic [1:0]  sel,
                                                 input int unsigned unit);
    cdv_period_len = 32'(unit) * 32'(VAR_UNITS_STEP) * ({30'h0, sel} + 32'h1);
  endfunction : cdv_period_len

endpackage : cdv_pkg

// ---- hw/cdv_var_acc.sv ----
// Variance period timer and sum of squares accumulator
module cdv_var_acc
  import cdv_pkg::*;
#(
  parameter int unsigned UNIT_CYC = VAR_UNIT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic        restart,
  input  wire logic [1:0]  period_sel,
  input  wire logic [7:0]  sample,
  input  wire logic        sample_valid,
  output logic             sum_done,
  output logic [31:0]      sum
);

  logic [31:0] tick_r;
  logic [31:0] acc_r;
  logic [31:0] sum_r;
  logic        done_r;
  logic [15:0] sq;
  logic [32:0] acc_add;
  logic        last;

  // ----------------------------------------------------------------
  // Square and saturating add
  // ----------------------------------------------------------------
  // squared receiver error
  assign sq      = 16'($signed(sample) * $signed(sample));
  assign acc_add = {1'b0, acc_r} + {17'h0, sq};
  // period in units of 2^17 cycles
  assign last    = (tick_r == cdv_period_len(period_sel, UNIT_CYC) - 32'h1);

  // ----------------------------------------------------------------
  // Period timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_r <= 32'h0;
      acc_r  <= 32'h0;
      done_r <= 1'b0;
      sum_r  <= 32'h0;
    end else if (!enable || restart) begin
      tick_r <= 32'h0;
      acc_r  <= 32'h0;
      done_r <= 1'b0;
    end else begin
      done_r <= last;
      if (last) begin
        tick_r <= 32'h0;
        acc_r  <= 32'h0;
        // Last cycle's sample is left out; its valid is never looked at
        sum_r  <= acc_r;
      end else begin
        tick_r <= tick_r + 32'h1;
        if (sample_valid) begin
          acc_r <= acc_add[32] ? 32'hFFFFFFFF : acc_add[31:0];
        end
      end
    end
  end

  assign sum_done = done_r;
  assign sum      = sum_r;

endmodule : cdv_var_acc

// ---- hw/cdv_top.sv ----
// Reflectometry capture and variance control behind an AHB-Lite slave
//
// Chosen here: the AHB-Lite register port.
module cdv_top
  import cdv_pkg::*;
#(
  parameter int unsigned UNIT_CYC = VAR_UNIT_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        send_pulse_bit,
  input  wire logic        min_mode_select,
  input  wire logic [5:0]  rx_threshold,
  input  wire logic [5:0]  reflect_sample,
  output logic             pulse_launch,
  output logic             capture_busy,
  output logic             capture_done,
  input  wire logic [7:0]  rx_var_sample,
  input  wire logic        rx_var_valid
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        acc_phase;
  logic        rd_acc;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic        wr_win;
  logic        wr_vctl;
  logic        rd_data_acc;
  logic [31:0] rdata_nxt;
  logic [31:0] hrdata_r;

  logic [7:0]  win_start_r;
  logic [7:0]  win_start_nxt;
  logic [7:0]  win_stop_r;
  logic [7:0]  win_stop_nxt;

  logic        send_d_r;
  logic        launch;
  cdv_cap_e    cap_state_r;
  logic [7:0]  win_time_r;
  logic        in_window;
  logic        mode_r;
  logic [5:0]  thr_r;
  logic        seen_r;
  logic        better;
  logic        meets;
  logic [5:0]  peak_val_r;
  logic [7:0]  peak_time_r;
  logic        thr_met_r;
  logic [7:0]  thr_time_r;
  logic        last_time;

  logic        var_en_r;
  logic        var_en_nxt;
  logic [1:0]  var_sel_r;
  logic [1:0]  var_sel_nxt;
  logic        var_frz_r;
  logic        var_frz_nxt;
  logic        var_rdy_r;
  logic        var_restart;
  logic        sum_done;
  logic [31:0] sum;
  logic [31:0] var_data_r;
  logic        half_r;
  logic        second_read;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Zero wait states; every answer is OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  assign acc_phase = hsel && htrans[1] && hready;
  assign rd_acc    = acc_phase && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= acc_phase && hwrite;
      if (acc_phase) begin
        wr_addr_r <= haddr;
      end
    end
  end

  assign wr_win  = wr_pend_r && cdv_hit(wr_addr_r, IDX_WIN_BOUNDS);
  assign wr_vctl = wr_pend_r && cdv_hit(wr_addr_r, IDX_VAR_CTRL);

  // ----------------------------------------------------------------
  // Window bounds register
  // ----------------------------------------------------------------
  // start and stop fields, read/write
  always_comb begin
    win_start_nxt = win_start_r;
    win_stop_nxt  = win_stop_r;
    if (wr_win) begin
      win_start_nxt = hwdata[WIN_START_LSB +: 8];
      win_stop_nxt  = hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_start_r <= WIN_START_RST;
      win_stop_r  <= WIN_STOP_RST;
    end else begin
      win_start_r <= win_start_nxt;
      win_stop_r  <= win_stop_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Capture sequencer
  // ----------------------------------------------------------------
  // rising send bit launches the pulse
  assign launch = send_pulse_bit && !send_d_r && (cap_state_r == CDV_CAP_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      send_d_r <= 1'b0;
    end else begin
      send_d_r <= send_pulse_bit;
    end
  end

  // window test is inclusive at both ends
  assign in_window = (win_time_r >= win_start_r) && (win_time_r <= win_stop_r);
  // a stop below start simply evaluates nothing
  assign last_time = (win_time_r == win_stop_r) || (win_time_r == TIME_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_state_r <= CDV_CAP_IDLE;
      win_time_r  <= 8'h00;
      mode_r      <= 1'b0;
      thr_r       <= 6'h00;
    end else begin
      case (cap_state_r)
        CDV_CAP_IDLE: begin
          if (launch) begin
            win_time_r  <= 8'h00;
            mode_r      <= min_mode_select;
            thr_r       <= rx_threshold;
            cap_state_r <= CDV_CAP_RUN;
          end
        end
        CDV_CAP_RUN: begin
          // one count per 8 ns clock
          if (last_time) begin
            cap_state_r <= CDV_CAP_DONE;
          end else begin
            win_time_r <= win_time_r + 8'h01;
          end
        end
        CDV_CAP_DONE: begin
          // Wait for the send bit to drop so one write gives one shot
          if (!send_pulse_bit) begin
            cap_state_r <= CDV_CAP_IDLE;
          end
        end
        default: begin
          cap_state_r <= CDV_CAP_IDLE;
        end
      endcase
    end
  end

  assign pulse_launch = launch;
  assign capture_busy = (cap_state_r == CDV_CAP_RUN);
  // done pulse clears the send bit
  assign capture_done = (cap_state_r == CDV_CAP_RUN) && last_time;

  // ----------------------------------------------------------------
  // Peak and threshold detection
  // ----------------------------------------------------------------
  // strict compare keeps the first extreme
  assign better = mode_r ? (reflect_sample < peak_val_r)
                         : (reflect_sample > peak_val_r);
  // above threshold in max mode, below in min mode
  assign meets  = mode_r ? (reflect_sample < thr_r)
                         : (reflect_sample > thr_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_r      <= 1'b0;
      peak_val_r  <= 6'h00;
      peak_time_r <= 8'h00;
      thr_met_r   <= 1'b0;
      thr_time_r  <= 8'h00;
    end else if (launch) begin
      // Old results are wiped at launch, not kept across shots
      seen_r      <= 1'b0;
      peak_val_r  <= min_mode_select ? SAMPLE_MAX : SAMPLE_MIN;
      peak_time_r <= 8'h00;
      thr_met_r   <= 1'b0;
      thr_time_r  <= 8'h00;
    end else if (capture_busy && in_window) begin
      seen_r <= 1'b1;
      // later equal samples leave the time alone
      if (!seen_r || better) begin
        peak_val_r  <= reflect_sample;
        peak_time_r <= win_time_r;
      end
      // flag set on any meeting sample
      // time of the first one only
      if (meets && !thr_met_r) begin
        thr_met_r  <= 1'b1;
        thr_time_r <= win_time_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Variance control register
  // ----------------------------------------------------------------
  assign rd_data_acc = rd_acc && cdv_hit(haddr, IDX_VAR_DATA);
  assign second_read = rd_data_acc && half_r;

  always_comb begin
    var_en_nxt  = var_en_r;
    var_sel_nxt = var_sel_r;
    var_frz_nxt = var_frz_r;
    // freeze drops after the second read
    if (second_read) begin
      var_frz_nxt = 1'b0;
    end
    if (wr_vctl) begin
      var_en_nxt  = hwdata[VAR_EN_BIT];
      var_sel_nxt = hwdata[VAR_SEL_LSB +: 2];
      var_frz_nxt = hwdata[VAR_FRZ_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      var_en_r  <= 1'b0;
      var_sel_r <= VAR_SEL_RST;
      var_frz_r <= 1'b0;
    end else begin
      var_en_r  <= var_en_nxt;
      var_sel_r <= var_sel_nxt;
      var_frz_r <= var_frz_nxt;
    end
  end

  // any write of the control register restarts
  assign var_restart = wr_vctl;

  // fed by the 100-Mb receiver samples
  cdv_var_acc #(
    .UNIT_CYC     (UNIT_CYC)
  ) u_acc (
    .clk          (hclk),
    .rst_n        (hresetn),
    .enable       (var_en_r),
    .restart      (var_restart),
    .period_sel   (var_sel_r),
    .sample       (rx_var_sample),
    .sample_valid (rx_var_valid),
    .sum_done     (sum_done),
    .sum          (sum)
  );

  // ----------------------------------------------------------------
  // Variance data and ready flag
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      var_data_r <= 32'h0;
      var_rdy_r  <= 1'b0;
    end else begin
      if (sum_done && !var_frz_r) begin
        var_data_r <= sum;
      end
      // new sum sets ready, set beats clear
      if (sum_done && !var_frz_r) begin
        var_rdy_r <= 1'b1;
      end else if (second_read) begin
        var_rdy_r <= 1'b0;
      end
    end
  end

  // Any other transfer breaks the read pair
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_r <= 1'b0;
    end else if (rd_data_acc) begin
      half_r <= !half_r;
    end else if (acc_phase) begin
      half_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Uses next values so a read right after a write sees it
  always_comb begin
    rdata_nxt = 32'h0;
    if (cdv_hit(haddr, IDX_WIN_BOUNDS)) begin
      rdata_nxt[15:0] = {win_start_nxt, win_stop_nxt};
    end else if (cdv_hit(haddr, IDX_PEAK_RES)) begin
      rdata_nxt[13:0] = {peak_val_r, peak_time_r};
    end else if (cdv_hit(haddr, IDX_THR_RES)) begin
      rdata_nxt[THR_MET_BIT:0] = {thr_met_r, thr_time_r};
    end else if (cdv_hit(haddr, IDX_VAR_CTRL)) begin
      rdata_nxt[VAR_RDY_BIT] = var_rdy_r;
      rdata_nxt[3:0]         = {var_frz_nxt, var_sel_nxt, var_en_nxt};
    end else if (cdv_hit(haddr, IDX_VAR_DATA)) begin
      // low half first, high half second
      rdata_nxt[15:0] = half_r ? var_data_r[31:16] : var_data_r[15:0];
    end
  end

  // results settle before the send bit clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0;
    end else if (rd_acc) begin
      hrdata_r <= rdata_nxt;
    end
  end

  // Size is not checked; only whole-word transfers are expected
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, htrans[0]};

endmodule : cdv_top

// ---- sim/cdv_top_monitor.sv ----
// Port checker for the cable diagnostic block, bound into its top module
module cdv_top_monitor
  import cdv_pkg::*;
#(
  parameter int unsigned UNIT_CYC = VAR_UNIT_CYCLES
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        send_pulse_bit,
  input wire logic        min_mode_select,
  input wire logic        pulse_launch,
  input wire logic        capture_busy,
  input wire logic        capture_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_take;
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Bus side
  // ----------------------------------------------------------------
  bus_okay_a: assert property (hreadyout && !hresp && hrdata[31:16] == 16'h0000)
    else $error("bus answer not okay or upper data set");
  peak_rsvd_a: assert property (rd_take && haddr == 8'h60 |=> hrdata[15:14] == 2'b00)
    else $error("peak reserved bits set");
  thr_rsvd_a: assert property (rd_take && haddr == 8'h64 |=> hrdata[15:9] == 7'h00)
    else $error("threshold reserved bits set");
  ctrl_rsvd_a: assert property (rd_take && haddr == 8'h68 |=> hrdata[14:4] == 11'h000)
    else $error("variance control reserved bits set");
  unmapped_zero_a: assert property (rd_take && !(haddr inside {8'h5C, 8'h60, 8'h64,
    8'h68, 8'h6C}) |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  // ----------------------------------------------------------------
  // Capture side
  // ----------------------------------------------------------------
  launch_cause_a: assert property (pulse_launch |-> send_pulse_bit
    && !$past(send_pulse_bit) && !capture_busy)
    else $error("launch without fresh send request");
  launch_busy_a: assert property (pulse_launch |=> capture_busy)
    else $error("no scan after launch");
  busy_holds_a: assert property (capture_busy && !capture_done |=> capture_busy)
    else $error("scan ended without done");
  done_drop_a: assert property (capture_done |-> capture_busy ##1 !capture_busy)
    else $error("done outside scan or scan kept");
  scan_bound_a: assert property ($rose(capture_busy) |-> ##[0:255] capture_done)
    else $error("scan longer than time range");
  cover property (pulse_launch && min_mode_select);
  cover property (capture_done);
  cover property (rd_take && haddr == 8'h6C);
endmodule : cdv_top_monitor

bind cdv_top cdv_top_monitor #(.UNIT_CYC(UNIT_CYC)) cdv_top_monitor_i (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .send_pulse_bit,
  .min_mode_select, .pulse_launch, .capture_busy, .capture_done);

// ---- sim/cdv_cable_model.sv ----
// Far-end model: cable echo samples and receiver error samples
module cdv_cable_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       pulse_launch,
  input  wire logic [7:0] amp,
  output logic      [5:0] reflect_sample,
  output logic      [7:0] rx_var_sample,
  output logic            rx_var_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] t_r;
  logic       sgn_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) t_r <= 8'h00;
    else if (pulse_launch) t_r <= 8'h00;
    else if (t_r != 8'hFF) t_r <= t_r + 8'h01;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sgn_r <= 1'b0;
    else sgn_r <= ~sgn_r;
  end
  // Repeated extremes, plus larger ones outside the window
  always_comb begin
    case (t_r)
      8'h03: reflect_sample = 6'h3F;
      8'h04: reflect_sample = 6'h10;
      8'h06: reflect_sample = 6'h30;
      8'h08: reflect_sample = 6'h30;
      8'h09: reflect_sample = 6'h10;
      8'h0B: reflect_sample = 6'h00;
      default: reflect_sample = 6'h20;
    endcase
  end
  // sign flips each cycle, so only a signed square sums right
  assign rx_var_sample = sgn_r ? amp : 8'h00 - amp;
  assign rx_var_valid = 1'b1;
endmodule : cdv_cable_model

// ---- sim/cdv_top_bench.sv ----
// Register-level bench for the cable diagnostic block
module cdv_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, send_pulse_bit, min_mode_select;
  logic [7:0]  haddr, amp, rx_var_sample;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [5:0]  rx_threshold, reflect_sample;
  logic        hreadyout, hresp, pulse_launch, capture_busy, capture_done, rx_var_valid;
  int          n_mismatch, total_checks, cyc;

  // Short unit so a period is 8 to 32 cycles
  cdv_top #(.UNIT_CYC(4)) cdv_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .send_pulse_bit,
    .min_mode_select, .rx_threshold, .reflect_sample, .pulse_launch, .capture_busy,
    .capture_done, .rx_var_sample, .rx_var_valid);
  cdv_cable_model cdv_cable_model_i (.hclk, .hresetn, .pulse_launch, .amp, .reflect_sample,
    .rx_var_sample, .rx_var_valid);

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task end_sim;
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // Run long enough for all scenarios, well short of a hang
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, exp, input logic [31:0] m = 32'hFFFF_FFFF);
    total_checks++;
    if ((got & m) !== (exp & m)) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Single word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask : xfer

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFF_FFFF);
    xfer(1'b0, a, 32'h0, rd);
    chk(rd, e, m);
  endtask : rchk

  // Neighbour role: raise send bit, drop it on done
  task automatic cap(input logic mode, input logic [5:0] thr);
    @(posedge hclk);
    min_mode_select <= mode;
    rx_threshold <= thr;
    send_pulse_bit <= 1'b1;
    for (int i = 0; i < 300 && capture_done !== 1'b1; i++) @(negedge hclk);
    chk({31'h0, capture_done}, 32'h1);
    @(posedge hclk);
    send_pulse_bit <= 1'b0;
  endtask : cap

  task automatic wait_rdy;
    for (int i = 0; i < 40; i++) begin
      xfer(1'b0, 8'h68, 32'h0, rd);
      if (rd[15] === 1'b1) break;
    end
  endtask : wait_rdy

  initial begin
    {hresetn, hsel, hwrite, send_pulse_bit, min_mode_select} = '0;
    {haddr, htrans, hwdata, rx_threshold} = '0;
    hsize = 3'b010;
    amp = 8'h03;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(8'h5C, 32'h0000_00FF);
    for (int a = 8'h60; a <= 8'h70; a += 4) rchk(a[7:0], 32'h0);
    xfer(1'b1, 8'h60, 32'hFFFF_FFFF, rd);
    rchk(8'h60, 32'h0);
    xfer(1'b1, 8'h70, 32'hFFFF_FFFF, rd);
    rchk(8'h70, 32'h0);
    xfer(1'b1, 8'h68, 32'hFFFF_FFFF, rd);
    rchk(8'h68, 32'h0000_000F);
    xfer(1'b1, 8'h68, 32'h0, rd);
    // ----------------------------------------------------------------
    // Capture: window 4..10, echoes outside it must be ignored
    // ----------------------------------------------------------------
    xfer(1'b1, 8'h5C, 32'h0000_040A, rd);
    rchk(8'h5C, 32'h0000_040A);
    cap(1'b0, 6'h28);
    rchk(8'h60, 32'h0000_3006);
    rchk(8'h64, 32'h0000_0106);
    cap(1'b1, 6'h12);
    rchk(8'h60, 32'h0000_1004);
    rchk(8'h64, 32'h0000_0104);
    cap(1'b0, 6'h30);
    rchk(8'h64, 32'h0, 32'hFFFF_FF00);
    // ----------------------------------------------------------------
    // Variance: 7 samples of square 9 per 8-cycle period
    // ----------------------------------------------------------------
    xfer(1'b1, 8'h68, 32'h1, rd);
    wait_rdy();
    chk(rd, 32'h0000_8001);
    xfer(1'b1, 8'h68, 32'h9, rd);
    amp <= 8'h02;
    repeat (30) @(posedge hclk);
    rchk(8'h68, 32'h0000_8009);
    xfer(1'b1, 8'h68, 32'h8, rd);
    rchk(8'h6C, 32'h0000_003F);
    rchk(8'h68, 32'h0000_8008);
    rchk(8'h6C, 32'h0000_003F);
    rchk(8'h6C, 32'h0);
    rchk(8'h68, 32'h0);
    xfer(1'b1, 8'h68, 32'h7, rd);
    repeat (25) @(posedge hclk);
    rchk(8'h68, 32'h0000_0007);
    wait_rdy();
    chk(rd, 32'h0000_8007);
    xfer(1'b1, 8'h68, 32'hE, rd);
    rchk(8'h6C, 32'h0000_007C);
    rchk(8'h6C, 32'h0);
    rchk(8'h68, 32'h0000_0006);
    repeat (40) @(posedge hclk);
    rchk(8'h68, 32'h0000_0006);
    xfer(1'b1, 8'h68, 32'h3, rd);
    wait_rdy();
    chk(rd, 32'h0000_8003);
    xfer(1'b1, 8'h68, 32'hB, rd);
    rchk(8'h6C, 32'h0000_003C);
    rchk(8'h6C, 32'h0);
    end_sim();
  end
endmodule : cdv_top_bench
